//--- rfic_pkg.sv
package rfic_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ     = 200;
  localparam int DEBOUNCE_TIME_US = 1000;
  localparam int DEBOUNCE_CYC     = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
  localparam int DB_CNT_W         = 18;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_PROFILE  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_NOHEAT_BIT = 0;
  localparam int CTRL_ACLR_BIT   = 1;
  localparam int CTRL_PROF_LSB   = 8;
  localparam int EV_DONE         = 0;
  localparam int EV_ABORT        = 1;
  localparam int EV_ESTOP        = 2;
  localparam int EV_ALARM        = 3;
  localparam int EV_PROF         = 4;
  localparam int EV_W            = 5;
  localparam logic [5:0] PROF_RST = 6'h01;
  localparam logic [5:0] PANEL_RST = 6'h00;

  // ----------------------------------------------------------------
  // Discrete input indices
  // ----------------------------------------------------------------
  localparam int IN_S1    = 0;
  localparam int IN_S2    = 1;
  localparam int IN_FIRE  = 2;
  localparam int IN_INH   = 3;
  localparam int IN_ACLR  = 4;
  localparam int IN_ESTOP = 5;
  localparam int IN_J12   = 6;
  localparam int IN_J23   = 7;
  localparam int IN_SEL   = 8;
  localparam int NUM_IN   = 14;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DOWN = 2'b01,
    ST_HEAT = 2'b10,
    ST_RET  = 2'b11
  } rfic_state_t;

  typedef enum logic [1:0] {
    TC_E = 2'b00,
    TC_J = 2'b01,
    TC_K = 2'b10
  } rfic_tc_t;

endpackage : rfic_pkg

//--- rfic_debounce.sv
`timescale 1ns/1ps
module rfic_debounce
  import rfic_pkg::*;
#(
  parameter int CYC = DEBOUNCE_CYC
)(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and results
  input  wire logic raw_n,
  output logic      sync_o,
  output logic      clean_o
);

  logic                meta_r;
  logic [DB_CNT_W-1:0] cnt_r;
  logic [DB_CNT_W-1:0] cnt_nxt;
  logic                clean_nxt;
  wire                 differs = sync_o != clean_o;
  wire                 settled = cnt_r == DB_CNT_W'(CYC - 1);

  // Two stage synchroniser, idle level is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_r <= raw_n;
      sync_o <= meta_r;
    end
  end

  assign cnt_nxt   = (differs && !settled) ? cnt_r + 1'b1 : '0;
  assign clean_nxt = (differs && settled) ? sync_o : clean_o;

  // Debounced level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r   <= '0;
      clean_o <= 1'b1;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      clean_o <= clean_nxt;
    end
  end

endmodule : rfic_debounce

//--- rfic_top.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - First pedal stage closed lowers the head.
// - First stage released before second: head returns home, no heat.
// - Second stage plus fire contact: heat cycle, then head home.
// - Remote heat inhibit acts as the local no-heat selector.
// - All select lines inactive: profile 1..63 comes from panel keys.
// - Any select line active: panel keys disabled, lines give profile.
// - Select lines are unsigned binary, line 0 least significant.
// - Profile zero is never selected; all-inactive means local choice.
// - Opened emergency stop retracts head at once from any state.
// - Alarm clear input clears pending alarms and out-of-limit flags.
// - Faulty auxiliary sensor raises no error indication; here it raises no alarm but reads as status bit 9.
// - Discrete inputs active low; floating high reads inactive.
module rfic_top
  import rfic_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Discrete pins, active low
  input  wire logic        pedal_stage1_n,
  input  wire logic        pedal_stage2_n,
  input  wire logic        fire_contact_n,
  input  wire logic        heat_inhibit_n,
  input  wire logic        alarm_clear_n,
  input  wire logic        estop_closed_n,
  input  wire logic        strap_12_n,
  input  wire logic        strap_23_n,
  input  wire logic [5:0]  profile_select_line_n,
  // Process logic, same clock
  input  wire logic        heat_done,
  input  wire logic        alarm_event,
  input  wire logic        limit_event,
  input  wire logic        aux_tc_fault,
  // Outputs
  output logic             head_drive,
  output logic             heat_enable,
  output logic [5:0]       active_profile,
  output logic             panel_keys_disabled,
  output logic             alarm_pending,
  output logic             limit_pending,
  output logic [1:0]       tc_type,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic rfic_tc_t tc_decode(input logic j12, input logic j23);
    rfic_tc_t t;
    t = TC_E;
    if (j12 && !j23)
      t = TC_J;
    else if (j23 && !j12)
      t = TC_K;
    return t;
  endfunction : tc_decode

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  wire [NUM_IN-1:0] pins_n = {profile_select_line_n, strap_23_n, strap_12_n,
                              estop_closed_n, alarm_clear_n, heat_inhibit_n,
                              fire_contact_n, pedal_stage2_n, pedal_stage1_n};
  logic [NUM_IN-1:0] sync_n;
  logic [NUM_IN-1:0] clean_n;

  // One conditioner per pin
  for (genvar i = 0; i < NUM_IN; i++)
  begin : g_in
    rfic_debounce #(.CYC(DEBOUNCE_CYCLES)) u_db (
      .pclk    (pclk),
      .presetn (presetn),
      .raw_n   (pins_n[i]),
      .sync_o  (sync_n[i]),
      .clean_o (clean_n[i])
    );
  end

  wire [NUM_IN-1:0] act = ~clean_n;
  wire              s1 = act[IN_S1];
  wire              s2 = act[IN_S2];
  wire              fire = act[IN_FIRE];
  // Open contact reads high; synced only so the retract is immediate
  wire              estop = sync_n[IN_ESTOP];
  wire [5:0]        sel = act[IN_SEL +: 6];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rfic_state_t     state_r;
  rfic_state_t     state_nxt;
  logic            estop_d_r;
  logic            no_heat_r;
  logic [5:0]      panel_r;
  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] en_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc     = psel && penable;
  wire wr      = acc && pready && pwrite;
  wire hit_ctl = paddr == OFF_CTRL;
  wire hit_st  = paddr == OFF_STATUS;
  wire hit_pr  = paddr == OFF_PROFILE;
  wire hit_is  = paddr == OFF_IRQ_STAT;
  wire hit_ie  = paddr == OFF_IRQ_EN;
  wire hit_ic  = paddr == OFF_IRQ_CLR;
  wire hit     = hit_ctl || hit_st || hit_pr || hit_is || hit_ie || hit_ic;
  wire wr_ctl  = wr && hit_ctl;
  wire sw_aclr = wr_ctl && pwdata[CTRL_ACLR_BIT];
  wire [EV_W-1:0] clr = (wr && hit_ic) ? pwdata[EV_W-1:0] : '0;

  // Read mux
  wire [31:0] rd_st = {22'h00_0000, aux_tc_fault, tc_type, limit_pending,
                       alarm_pending, estop, heat_enable, head_drive, state_r};
  wire [31:0] rd_mux =
    hit_ctl ? {18'h0_0000, panel_r, 7'h00, no_heat_r} :
    hit_st  ? rd_st :
    hit_pr  ? {25'h000_0000, panel_keys_disabled, active_profile} :
    hit_is  ? {27'h000_0000, stat_r} :
    hit_ie  ? {27'h000_0000, en_r} : 32'h0000_0000;

  // Answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      prdata  <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control and enable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      no_heat_r <= 1'b0;
      panel_r   <= PANEL_RST;
      en_r      <= '0;
    end
    else
    begin
      if (wr_ctl)
      begin
        no_heat_r <= pwdata[CTRL_NOHEAT_BIT];
        panel_r   <= pwdata[CTRL_PROF_LSB +: 6];
      end
      if (wr && hit_ie)
        en_r <= pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Head and heat sequence
  // ----------------------------------------------------------------
  // Remote inhibit merged with local selector
  wire no_heat = no_heat_r || act[IN_INH];
  wire blocked = estop || alarm_pending || limit_pending;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (s1 && !blocked)
          state_nxt = ST_DOWN;
      ST_DOWN:
        if (!s1)
          state_nxt = ST_RET;
        else if (s2 && fire)
          state_nxt = no_heat ? ST_RET : ST_HEAT;
      ST_HEAT:
        if (heat_done || alarm_event)
          state_nxt = ST_RET;
      ST_RET:
        if (!s1 && !s2)
          state_nxt = ST_IDLE;
    endcase
    if (estop && state_r != ST_IDLE)
      state_nxt = ST_RET;
  end

  wire head_nxt = state_nxt == ST_DOWN || state_nxt == ST_HEAT;

  // Sequence state and drives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= ST_IDLE;
      head_drive  <= 1'b0;
      heat_enable <= 1'b0;
      estop_d_r   <= 1'b1;
    end
    else
    begin
      state_r     <= state_nxt;
      head_drive  <= head_nxt;
      heat_enable <= state_nxt == ST_HEAT;
      estop_d_r   <= estop;
    end
  end

  // ----------------------------------------------------------------
  // Profile selection
  // ----------------------------------------------------------------
  // Remote binary code wins
  wire       sel_any = |sel;
  wire [5:0] prof_nxt = sel_any ? sel :
                        (panel_r != 6'h00) ? panel_r : active_profile;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_profile      <= PROF_RST;
      panel_keys_disabled <= 1'b0;
    end
    else
    begin
      active_profile      <= prof_nxt;
      panel_keys_disabled <= sel_any;
    end
  end

  // ----------------------------------------------------------------
  // Alarms, strap, interrupts
  // ----------------------------------------------------------------
  // Clear from pin or software, new event wins
  wire aclr = act[IN_ACLR] || sw_aclr;
  // Auxiliary fault is not an alarm source
  wire alarm_nxt = alarm_event || (alarm_pending && !aclr);
  wire limit_nxt = limit_event || (limit_pending && !aclr);

  // Strap code as seen this cycle, for the decode check
  rfic_tc_t  tc_dec;
  assign tc_dec = tc_decode(act[IN_J12], act[IN_J23]);

  // Event sources
  wire [EV_W-1:0] ev;
  assign ev[EV_DONE]  = state_r == ST_HEAT && heat_done && !estop;
  assign ev[EV_ABORT] = state_r == ST_DOWN && !s1 && !estop;
  assign ev[EV_ESTOP] = estop && !estop_d_r;
  assign ev[EV_ALARM] = alarm_event || limit_event;
  assign ev[EV_PROF]  = prof_nxt != active_profile;
  wire [EV_W-1:0] stat_nxt = (stat_r & ~clr) | ev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_pending <= 1'b0;
      limit_pending <= 1'b0;
      tc_type       <= TC_E;
      stat_r        <= '0;
      irq           <= 1'b0;
    end
    else
    begin
      alarm_pending <= alarm_nxt;
      limit_pending <= limit_nxt;
      tc_type       <= tc_decode(act[IN_J12], act[IN_J23]);
      stat_r        <= stat_nxt;
      irq           <= |(stat_nxt & en_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_head_down;
    (state_r == ST_IDLE && s1 && !blocked) |=> head_drive && !heat_enable;
  endproperty
  a_head_down: assert property (p_head_down) else $error("head not lowered");

  property p_abort;
    (state_r == ST_DOWN && !s1) |=> !head_drive && !heat_enable ##1 !heat_enable;
  endproperty
  a_abort: assert property (p_abort) else $error("abort still driving");

  property p_heat;
    (state_r == ST_DOWN && s1 && s2 && fire && !no_heat && !estop)
      |=> heat_enable && head_drive;
  endproperty
  a_heat: assert property (p_heat) else $error("heat not started");

  property p_heat_end;
    (state_r == ST_HEAT && heat_done) |=> !head_drive && !heat_enable;
  endproperty
  a_heat_end: assert property (p_heat_end) else $error("head not home");

  property p_inhibit;
    (state_r == ST_DOWN && s1 && s2 && fire && act[IN_INH]) |=> !heat_enable;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("heat despite inhibit");

  property p_remote;
    sel_any |=> panel_keys_disabled && active_profile == $past(sel);
  endproperty
  a_remote: assert property (p_remote) else $error("remote code ignored");

  property p_local;
    (!sel_any && panel_r != 6'h00) |=> active_profile == $past(panel_r);
  endproperty
  a_local: assert property (p_local) else $error("panel value ignored");

  property p_no_zero;
    active_profile != 6'h00;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("profile zero");

  property p_estop;
    estop |=> !head_drive && !heat_enable;
  endproperty
  a_estop: assert property (p_estop) else $error("stop ignored");

  property p_aclr;
    (aclr && !alarm_event && !limit_event) |=> !alarm_pending && !limit_pending;
  endproperty
  a_aclr: assert property (p_aclr) else $error("alarm not cleared");

  property p_strap;
    tc_type == $past(tc_dec);
  endproperty
  a_strap: assert property (p_strap) else $error("strap decode wrong");

  property p_aux;
    (aux_tc_fault && !alarm_event && !limit_event && !alarm_pending && !limit_pending)
      |=> !alarm_pending && !limit_pending;
  endproperty
  a_aux: assert property (p_aux) else $error("spurious alarm");

  c_cycle: cover property (state_r == ST_HEAT ##[1:50] state_r == ST_RET);
  c_abort: cover property (state_r == ST_DOWN ##1 state_r == ST_RET && !ev[EV_DONE]);
  c_remote: cover property (sel_any ##1 panel_keys_disabled);
  c_irq: cover property ($rose(irq));

endmodule : rfic_top

//--- rfic_plc_model.sv
`timescale 1ns/1ps
module rfic_plc_model (
  // Clock
  input  wire logic pclk,
  // Pedal and control pins, active low
  output logic       pedal_stage1_n,
  output logic       pedal_stage2_n,
  output logic       fire_contact_n,
  output logic       heat_inhibit_n,
  output logic       alarm_clear_n,
  output logic       estop_closed_n,
  output logic       strap_12_n,
  output logic       strap_23_n,
  output logic [5:0] profile_select_line_n
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // open inputs float high
  initial
  begin
    {pedal_stage1_n, pedal_stage2_n, fire_contact_n, heat_inhibit_n} = 4'hF;
    {alarm_clear_n, strap_12_n, strap_23_n} = 3'h7;
    estop_closed_n        = 1'b0;
    profile_select_line_n = 6'h3F;
  end

  task pedal(input logic s1, input logic s2);
    @(posedge pclk);
    pedal_stage1_n <= ~s1;
    pedal_stage2_n <= ~s2;
  endtask : pedal

  task single(input logic on);
    pedal(on, on);
  endtask : single

  // Fire, inhibit, alarm clear, stop button
  task ctl(input logic fire, input logic inh, input logic aclr, input logic eopen);
    @(posedge pclk);
    fire_contact_n <= ~fire;
    heat_inhibit_n <= ~inh;
    alarm_clear_n  <= ~aclr;
    estop_closed_n <= eopen;
  endtask : ctl

  // Sensor type strap
  task strap(input logic j12, input logic j23);
    @(posedge pclk);
    strap_12_n <= ~j12;
    strap_23_n <= ~j23;
  endtask : strap

  task sel(input logic [5:0] code);
    @(posedge pclk);
    profile_select_line_n <= ~code;
  endtask : sel
endmodule : rfic_plc_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rfic_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pedal_stage1_n, pedal_stage2_n, fire_contact_n, heat_inhibit_n;
  logic        alarm_clear_n, estop_closed_n, strap_12_n, strap_23_n;
  logic [5:0]  profile_select_line_n, active_profile;
  logic        heat_done, alarm_event, limit_event, aux_tc_fault;
  logic        head_drive, heat_enable, panel_keys_disabled;
  logic        alarm_pending, limit_pending, irq;
  logic [1:0]  tc_type;
  int          err_total, tests_run;

  // ----------------------------------------------------------------
  // Design and pin driver
  // ----------------------------------------------------------------
  rfic_top #(.DEBOUNCE_CYCLES(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pedal_stage1_n, .pedal_stage2_n, .fire_contact_n, .heat_inhibit_n,
    .alarm_clear_n, .estop_closed_n, .strap_12_n, .strap_23_n, .profile_select_line_n,
    .heat_done, .alarm_event, .limit_event, .aux_tc_fault, .head_drive, .heat_enable,
    .active_profile, .panel_keys_disabled, .alarm_pending, .limit_pending, .tc_type, .irq
  );

  rfic_plc_model plc (
    .pclk, .pedal_stage1_n, .pedal_stage2_n, .fire_contact_n, .heat_inhibit_n,
    .alarm_clear_n, .estop_closed_n, .strap_12_n, .strap_23_n, .profile_select_line_n
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task close_out();
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  // Wait n edges, then sample settled
  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // One APB transfer, held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wreg

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rchk

  // Pulse heat_done, alarm_event, limit_event
  task ev(input logic [2:0] m);
    @(posedge pclk);
    heat_done   <= m[2];
    alarm_event <= m[1];
    limit_event <= m[0];
    @(posedge pclk);
    heat_done   <= 1'b0;
    alarm_event <= 1'b0;
    limit_event <= 1'b0;
    wt(2);
  endtask : ev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    wt(1);
    chk("prof_rst", 32'h0000_0001, active_profile);
    chk("tc_rst", 32'h0000_0000, tc_type);
    chk("irq_rst", 32'h0000_0000, irq);
    rchk("ctrl_rst", OFF_CTRL, 32'h0000_0000);
  endtask : t_reset

  task t_abort();
    plc.pedal(1'b1, 1'b0);
    plc.pedal(1'b0, 1'b0);
    wt(12);
    chk("head_glitch", 1'b0, head_drive);
    plc.pedal(1'b1, 1'b0);
    wt(12);
    chk("head_down", 1'b1, head_drive);
    plc.pedal(1'b0, 1'b0);
    wt(12);
    chk("head_abort", 1'b0, head_drive);
    chk("heat_abort", 1'b0, heat_enable);
  endtask : t_abort

  task t_heat();
    plc.single(1'b1);
    plc.ctl(1'b1, 1'b0, 1'b0, 1'b0);
    wt(12);
    chk("heat_on", 1'b1, heat_enable);
    ev(3'b100);
    chk("head_home", 1'b0, head_drive);
    chk("heat_off", 1'b0, heat_enable);
    plc.single(1'b0);
    plc.ctl(1'b0, 1'b0, 1'b0, 1'b0);
    wt(12);
  endtask : t_heat

  task t_inhibit();
    for (int i = 0; i < 2; i++)
    begin
      plc.ctl(1'b0, i == 0, 1'b0, 1'b0);
      wreg(OFF_CTRL, 32'(i));
      wt(12);
      plc.single(1'b1);
      plc.ctl(1'b1, i == 0, 1'b0, 1'b0);
      wt(12);
      chk("heat_inhibit", 1'b0, heat_enable);
      chk("head_inhibit", 1'b0, head_drive);
      plc.single(1'b0);
      plc.ctl(1'b0, 1'b0, 1'b0, 1'b0);
      wreg(OFF_CTRL, 32'h0000_0000);
      wt(12);
    end
  endtask : t_inhibit

  task t_estop();
    plc.pedal(1'b1, 1'b0);
    wt(12);
    chk("head_pre", 1'b1, head_drive);
    plc.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    wt(5);
    chk("head_estop", 1'b0, head_drive);
    wt(12);
    chk("head_held", 1'b0, head_drive);
    plc.pedal(1'b0, 1'b0);
    plc.ctl(1'b0, 1'b0, 1'b0, 1'b0);
    wt(12);
  endtask : t_estop

  task t_alarm();
    ev(3'b010);
    chk("alarm_set", 1'b1, alarm_pending);
    ev(3'b001);
    chk("limit_set", 1'b1, limit_pending);
    plc.pedal(1'b1, 1'b0);
    wt(12);
    chk("head_refused", 1'b0, head_drive);
    plc.pedal(1'b0, 1'b0);
    plc.ctl(1'b0, 1'b0, 1'b1, 1'b0);
    wt(12);
    chk("alarm_pin_clr", 1'b0, alarm_pending);
    chk("limit_pin_clr", 1'b0, limit_pending);
    plc.ctl(1'b0, 1'b0, 1'b0, 1'b0);
    wt(12);
    ev(3'b011);
    wreg(OFF_CTRL, 32'h0000_0002);
    wt(3);
    chk("alarm_reg_clr", 1'b0, alarm_pending);
    chk("limit_reg_clr", 1'b0, limit_pending);
  endtask : t_alarm

  task t_profile();
    logic [5:0] codes [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F, 6'h2A};
    wreg(OFF_CTRL, 32'h0000_0500);
    wt(3);
    chk("panel_prof", 32'h0000_0005, active_profile);
    chk("keys_free", 1'b0, panel_keys_disabled);
    wreg(OFF_CTRL, 32'h0000_0000);
    wt(3);
    rchk("prof_zero", OFF_PROFILE, 32'h0000_0005);
    foreach (codes[k])
    begin
      plc.sel(codes[k]);
      wt(12);
      chk("sel_prof", codes[k], active_profile);
      chk("keys_off", 1'b1, panel_keys_disabled);
    end
    wreg(OFF_CTRL, 32'h0000_0700);
    wt(3);
    chk("keys_locked", 32'h0000_002A, active_profile);
    plc.sel(6'h00);
    wt(12);
    chk("keys_back", 1'b0, panel_keys_disabled);
    chk("prof_back", 32'h0000_0007, active_profile);
    wreg(OFF_CTRL, 32'h0000_0900);
    wt(3);
    chk("panel_again", 32'h0000_0009, active_profile);
  endtask : t_profile

  task t_strap();
    logic [1:0] exp [4] = '{TC_E, TC_J, TC_K, TC_E};
    for (int i = 0; i < 4; i++)
    begin
      plc.strap(i[0], i[1]);
      wt(12);
      chk("tc_type", exp[i], tc_type);
    end
    plc.strap(1'b0, 1'b0);
    wt(12);
  endtask : t_strap

  task t_aux();
    @(posedge pclk);
    aux_tc_fault <= 1'b1;
    wt(4);
    chk("aux_alarm", 1'b0, alarm_pending);
    rchk("aux_status", OFF_STATUS, 32'h0000_0200);
    @(posedge pclk);
    aux_tc_fault <= 1'b0;
  endtask : t_aux

  task t_irq();
    chk("irq_masked", 1'b0, irq);
    rchk("irq_stat", OFF_IRQ_STAT, 32'h0000_001F);
    wreg(OFF_IRQ_EN, 32'h0000_001F);
    wt(2);
    chk("irq_on", 1'b1, irq);
    rchk("irq_en", OFF_IRQ_EN, 32'h0000_001F);
    wreg(OFF_IRQ_EN, 32'h0000_0000);
    wt(2);
    chk("irq_mask", 1'b0, irq);
    wreg(OFF_IRQ_EN, 32'h0000_001F);
    wreg(OFF_IRQ_CLR, 32'h0000_001F);
    wt(2);
    chk("irq_clr", 1'b0, irq);
    rchk("stat_clr", OFF_IRQ_STAT, 32'h0000_0000);
    rchk("clr_read", OFF_IRQ_CLR, 32'h0000_0000);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", 1'b1, err);
  endtask : t_irq

  // ----------------------------------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    presetn   = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    heat_done    = 1'b0;
    alarm_event  = 1'b0;
    limit_event  = 1'b0;
    aux_tc_fault = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    err_total = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_abort();
    t_heat();
    t_inhibit();
    t_estop();
    t_alarm();
    t_profile();
    t_strap();
    t_aux();
    t_irq();
    close_out();
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    #100000;
    err_total++;
    close_out();
  end
endmodule : tb_top
